// ### design/ufc_cache.v
// Unified four-way set-associative cache with AHB-Lite control
// Behaviour
// - One 4-way array, 256 lines per way, 16-byte lines, 16 kbytes.
// - Bits 31..29 pick area; 101 and 111 never cached.
// - Top three address bits forced to zero before lookup and storage.
// - 22-bit tag from bits 31..10, top three stored as zero.
// - Each line has a live flag and a dirty flag.
// - Power-on reset clears live and dirty; manual reset keeps them.
// - Tag and data storage are never initialised by any reset.
// - Set index is address bits 11..4.
// - Allocation always fills a whole line of four words.
// - Six history bits per set; victim is least recently used way.
// - Listed six patterns choose way 3.
// - Listed six patterns choose way 2.
// - Listed six patterns choose way 1.
// - Listed six patterns choose way 0.
// - Power-on reset sets history to 000000; manual reset keeps it.
// - Only ways 2 and 3 can be locked.
// - Cache enable 0 bypasses all accesses; 1 caches cacheable areas.
// - Invalidate command clears flags and history, no write-back.
// - Area one uses write-back select; areas zero, three write-through.
//
// Decided for this implementation: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
`include "ufc_cache_regs.vh"
module ufc_cache #(
  parameter SETS = 256,
  parameter WAYS = 4
) (
  // Clock and resets
  input wire CLOCK_I,
  input wire RST_I,
  input wire MRST_I,
  // AHB-Lite register slave
  input wire HSEL_I,
  input wire [31:0] HADDR_I,
  input wire [1:0] HTRANS_I,
  input wire HWRITE_I,
  input wire [2:0] HSIZE_I,
  input wire [31:0] HWDATA_I,
  input wire HREADY_I,
  output reg HREADYOUT_O,
  output reg HRESP_O,
  output reg [31:0] HRDATA_O,
  // CPU access port
  input wire CPU_REQ_I,
  input wire CPU_WE_I,
  input wire [31:0] CPU_ADDR_I,
  input wire [31:0] CPU_WDATA_I,
  output reg CPU_ACK_O,
  output reg [31:0] CPU_RDATA_O,
  // External memory port, one word per handshake
  output reg MEM_REQ_O,
  output reg MEM_WE_O,
  output reg [31:0] MEM_ADDR_O,
  output reg [31:0] MEM_WDATA_O,
  input wire MEM_ACK_I,
  input wire [31:0] MEM_RDATA_I
);
  localparam ENTRIES = SETS * WAYS;
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_LOOK = 6'h02;
  localparam [5:0] S_WBACK = 6'h04;
  localparam [5:0] S_FILL = 6'h08;
  localparam [5:0] S_UNC = 6'h10;
  localparam [5:0] S_DONE = 6'h20;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  reg cache_on_bit_reg;
  reg write_through_select_reg;
  reg write_back_select_reg;
  reg lock_en_reg;
  reg w2lock_reg;
  reg w3lock_reg;
  reg invalidate_all_cmd_reg;
  reg last_hit_reg;
  reg ahb_sel_reg;
  reg ahb_wr_reg;
  reg [7:0] ahb_addr_reg;
  reg [5:0] state_reg;

  wire ahb_take = HSEL_I & HREADY_I & HTRANS_I[1];
  wire [7:0] ahb_ofs = HADDR_I[7:0];

  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
      HRDATA_O <= `UFC_ZERO32;
      ahb_sel_reg <= 1'b0;
      ahb_wr_reg <= 1'b0;
      ahb_addr_reg <= `UFC_CTRL_OFS;
    end else begin
      // Zero-wait slave, always OKAY; read data fetched in address phase
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
      ahb_sel_reg <= ahb_take;
      ahb_wr_reg <= HWRITE_I;
      ahb_addr_reg <= ahb_ofs;
      HRDATA_O <= `UFC_ZERO32;
      if (ahb_take && !HWRITE_I) begin
        case (ahb_ofs)
          `UFC_CTRL_OFS: begin
            HRDATA_O[`UFC_CE_BIT] <= cache_on_bit_reg;
            HRDATA_O[`UFC_WT_BIT] <= write_through_select_reg;
            HRDATA_O[`UFC_WB_BIT] <= write_back_select_reg;
            // Invalidate command bit always reads 0
            HRDATA_O[`UFC_CF_BIT] <= 1'b0;
          end
          `UFC_LOCK_OFS: begin
            HRDATA_O[`UFC_W2LOCK_BIT] <= w2lock_reg;
            HRDATA_O[`UFC_W3LOCK_BIT] <= w3lock_reg;
            HRDATA_O[`UFC_LE_BIT] <= lock_en_reg;
          end
          `UFC_STAT_OFS: begin
            HRDATA_O[`UFC_BUSY_BIT] <= (state_reg != S_IDLE);
            HRDATA_O[`UFC_HIT_BIT] <= last_hit_reg;
          end
          default: begin
            HRDATA_O <= `UFC_ZERO32;
          end
        endcase
      end
    end
  end

  // Both resets restore the control bits; only power-on touches the array
  always @(posedge CLOCK_I) begin
    if (RST_I || MRST_I) begin
      cache_on_bit_reg <= 1'b0;
      write_through_select_reg <= 1'b0;
      write_back_select_reg <= 1'b0;
      lock_en_reg <= 1'b0;
      w2lock_reg <= 1'b0;
      w3lock_reg <= 1'b0;
      invalidate_all_cmd_reg <= 1'b0;
    end else begin
      invalidate_all_cmd_reg <= 1'b0;
      if (ahb_sel_reg && ahb_wr_reg) begin
        if (ahb_addr_reg == `UFC_CTRL_OFS) begin
          cache_on_bit_reg <= HWDATA_I[`UFC_CE_BIT];
          write_through_select_reg <= HWDATA_I[`UFC_WT_BIT];
          write_back_select_reg <= HWDATA_I[`UFC_WB_BIT];
          invalidate_all_cmd_reg <= HWDATA_I[`UFC_CF_BIT];
        end
        if (ahb_addr_reg == `UFC_LOCK_OFS) begin
          w2lock_reg <= HWDATA_I[`UFC_W2LOCK_BIT];
          w3lock_reg <= HWDATA_I[`UFC_W3LOCK_BIT];
          lock_en_reg <= HWDATA_I[`UFC_LE_BIT];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  reg req_we_reg;
  reg [31:0] req_addr_reg;
  reg [31:0] req_wdata_reg;
  reg [1:0] way_reg;
  reg [1:0] cnt_reg;

  wire [2:0] area = req_addr_reg[31:29];
  // Shadow bits dropped so aliases share one cached line
  wire [31:0] phys = {`UFC_SHADOW_ZERO, req_addr_reg[28:0]};
  wire [21:0] tag = phys[31:10];
  wire [7:0] set = phys[11:4];
  wire [1:0] word = phys[3:2];
  wire cacheable = cache_on_bit_reg && (area != `UFC_AREA_TWO) &&
    (area != `UFC_AREA_IO);
  wire wb_mode = (area == `UFC_AREA_ONE) ? write_back_select_reg :
    ~write_through_select_reg;

  // ----------------------------------------------------------------
  // Storage: tags and data have no reset
  // ----------------------------------------------------------------
  reg [21:0] tag_mem [0:ENTRIES-1];
  reg [127:0] data_mem [0:ENTRIES-1];
  reg [ENTRIES-1:0] live_reg;
  reg [ENTRIES-1:0] dirty_reg;
  reg [5:0] lru_reg [0:SETS-1];

  wire [3:0] hit_way;
  genvar w;
  generate
    for (w = 0; w < WAYS; w = w + 1) begin : g_hit
      assign hit_way[w] = live_reg[{w[1:0], set}] &&
        (tag_mem[{w[1:0], set}] == tag);
    end
  endgenerate
  wire hit = |hit_way;
  wire [1:0] hit_idx = hit_way[3] ? 2'h3 : hit_way[2] ? 2'h2 :
    hit_way[1] ? 2'h1 : 2'h0;
  wire [9:0] hit_ent = {hit_idx, set};
  wire [127:0] hit_line = data_mem[hit_ent];

  // Victim choice from the set's history, with lockable ways masked
  wire [3:0] lock_mask = {lock_en_reg & w3lock_reg,
    lock_en_reg & w2lock_reg, 2'h0};
  wire [1:0] victim;
  wire [5:0] lru_touched;
  ufc_lru_pick u_pick (
    .lru_i(lru_reg[set]),
    .lock_i(lock_mask),
    .touch_way_i(hit_idx),
    .victim_o(victim),
    .touched_o(lru_touched)
  );
  wire [9:0] vic_ent = {victim, set};
  wire [9:0] fill_ent = {way_reg, set};

  // Strobes that change the array, decided by the controller state
  wire look = state_reg[1];
  wire hit_touch = look && cacheable && hit;
  wire hit_write = hit_touch && req_we_reg;
  wire fill_word = state_reg[3] && MEM_ACK_I;
  wire fill_end = fill_word && (cnt_reg == `UFC_WORD_LAST);

  always @(posedge CLOCK_I) begin
    if (hit_write) begin
      data_mem[hit_ent][word*32 +: 32] <= req_wdata_reg;
    end
    if (fill_word) begin
      data_mem[fill_ent][cnt_reg*32 +: 32] <= MEM_RDATA_I;
    end
    if (fill_end) begin
      tag_mem[fill_ent] <= tag;
    end
  end

  // ----------------------------------------------------------------
  // Per-entry flags and per-set history
  // ----------------------------------------------------------------
  genvar e;
  generate
    for (e = 0; e < ENTRIES; e = e + 1) begin : g_flag
      always @(posedge CLOCK_I) begin
        // Manual reset deliberately absent here
        if (RST_I || invalidate_all_cmd_reg) begin
          live_reg[e] <= 1'b0;
          dirty_reg[e] <= 1'b0;
        end else if (fill_end && fill_ent == e) begin
          live_reg[e] <= 1'b1;
          dirty_reg[e] <= 1'b0;
        end else if (hit_write && wb_mode && hit_ent == e) begin
          dirty_reg[e] <= 1'b1;
        end
      end
    end
    for (e = 0; e < SETS; e = e + 1) begin : g_lru
      always @(posedge CLOCK_I) begin
        if (RST_I || invalidate_all_cmd_reg) begin
          lru_reg[e] <= `UFC_LRU_RST;
        end else if (hit_touch && set == e) begin
          lru_reg[e] <= lru_touched;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Access controller
  // ----------------------------------------------------------------
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      state_reg <= S_IDLE;
      req_we_reg <= 1'b0;
      req_addr_reg <= `UFC_ZERO32;
      req_wdata_reg <= `UFC_ZERO32;
      way_reg <= 2'h0;
      cnt_reg <= 2'h0;
      last_hit_reg <= 1'b0;
      CPU_ACK_O <= 1'b0;
      CPU_RDATA_O <= `UFC_ZERO32;
      MEM_REQ_O <= 1'b0;
      MEM_WE_O <= 1'b0;
      MEM_ADDR_O <= `UFC_ZERO32;
      MEM_WDATA_O <= `UFC_ZERO32;
    end else begin
      CPU_ACK_O <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (CPU_REQ_I) begin
            req_we_reg <= CPU_WE_I;
            req_addr_reg <= CPU_ADDR_I;
            req_wdata_reg <= CPU_WDATA_I;
            state_reg <= S_LOOK;
          end
        end
        S_LOOK: begin
          last_hit_reg <= cacheable && hit;
          if (!cacheable || (!hit && req_we_reg && !wb_mode)) begin
            // Bypass, or write-through miss with no allocation
            MEM_REQ_O <= 1'b1;
            MEM_WE_O <= req_we_reg;
            MEM_ADDR_O <= cacheable ? phys : req_addr_reg;
            MEM_WDATA_O <= req_wdata_reg;
            state_reg <= S_UNC;
          end else if (hit) begin
            CPU_RDATA_O <= hit_line[word*32 +: 32];
            if (req_we_reg && !wb_mode) begin
              MEM_REQ_O <= 1'b1;
              MEM_WE_O <= 1'b1;
              MEM_ADDR_O <= phys;
              MEM_WDATA_O <= req_wdata_reg;
              state_reg <= S_UNC;
            end else begin
              CPU_ACK_O <= 1'b1;
              state_reg <= S_DONE;
            end
          end else begin
            way_reg <= victim;
            cnt_reg <= 2'h0;
            MEM_REQ_O <= 1'b1;
            if (live_reg[vic_ent] && dirty_reg[vic_ent]) begin
              MEM_WE_O <= 1'b1;
              MEM_ADDR_O <= {tag_mem[vic_ent], set[5:0], 4'h0};
              MEM_WDATA_O <= data_mem[vic_ent][31:0];
              state_reg <= S_WBACK;
            end else begin
              MEM_WE_O <= 1'b0;
              MEM_ADDR_O <= {tag, set[5:0], 4'h0};
              state_reg <= S_FILL;
            end
          end
        end
        S_WBACK: begin
          if (MEM_ACK_I) begin
            cnt_reg <= cnt_reg + 2'h1;
            if (cnt_reg == `UFC_WORD_LAST) begin
              MEM_WE_O <= 1'b0;
              MEM_ADDR_O <= {tag, set[5:0], 4'h0};
              state_reg <= S_FILL;
            end else begin
              MEM_ADDR_O <= {tag_mem[fill_ent], set[5:0],
                cnt_reg + 2'h1, 2'h0};
              MEM_WDATA_O <= data_mem[fill_ent][(cnt_reg + 2'h1)*32 +: 32];
            end
          end
        end
        S_FILL: begin
          if (MEM_ACK_I) begin
            cnt_reg <= cnt_reg + 2'h1;
            MEM_ADDR_O <= {tag, set[5:0], cnt_reg + 2'h1, 2'h0};
            if (cnt_reg == `UFC_WORD_LAST) begin
              // Line complete; re-run lookup so it hits and ages the set
              MEM_REQ_O <= 1'b0;
              state_reg <= S_LOOK;
            end
          end
        end
        S_UNC: begin
          if (MEM_ACK_I) begin
            MEM_REQ_O <= 1'b0;
            MEM_WE_O <= 1'b0;
            CPU_RDATA_O <= MEM_RDATA_I;
            CPU_ACK_O <= 1'b1;
            state_reg <= S_DONE;
          end
        end
        S_DONE: begin
          // One spare cycle so the acknowledged request is not retaken
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule // ufc_cache

// ### design/ufc_cache_regs.vh
// Constants for the unified four-way cache: map, fields, areas
`ifndef UFC_CACHE_REGS_VH
`define UFC_CACHE_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets (low address byte)
// ----------------------------------------------------------------
`define UFC_CTRL_OFS 8'h00
`define UFC_LOCK_OFS 8'h04
`define UFC_STAT_OFS 8'h08

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define UFC_CE_BIT 0
`define UFC_WT_BIT 1
`define UFC_WB_BIT 2
`define UFC_CF_BIT 3
`define UFC_CTRL_RST 4'h0

// ----------------------------------------------------------------
// Lock register fields
// ----------------------------------------------------------------
`define UFC_W2LOCK_BIT 0
`define UFC_W3LOCK_BIT 8
`define UFC_LE_BIT 16

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define UFC_BUSY_BIT 0
`define UFC_HIT_BIT 1

// ----------------------------------------------------------------
// Address areas, bits 31..29
// ----------------------------------------------------------------
`define UFC_AREA_ONE 3'h4
`define UFC_AREA_TWO 3'h5
`define UFC_AREA_THREE 3'h6
`define UFC_AREA_IO 3'h7

// ----------------------------------------------------------------
// Line and history constants
// ----------------------------------------------------------------
`define UFC_LRU_RST 6'h00
`define UFC_WORD_LAST 2'h3
`define UFC_SHADOW_ZERO 3'h0
`define UFC_ZERO32 32'h0000_0000

`endif

// ### design/ufc_lru_pick.v
// Victim choice and most-recent update for one set's history bits
`timescale 1ns/100ps
module ufc_lru_pick (
  // History bits and lock mask
  input wire [5:0] lru_i,
  input wire [3:0] lock_i,
  // Way just accessed
  input wire [1:0] touch_way_i,
  // Results
  output reg [1:0] victim_o,
  output reg [5:0] touched_o
);
  // Pair bits: 1 means the lower-numbered way is the older one
  wire o01 = lru_i[5];
  wire o02 = lru_i[4];
  wire o03 = lru_i[3];
  wire o12 = lru_i[2];
  wire o13 = lru_i[1];
  wire o23 = lru_i[0];
  // Ways 0 and 1 can never be locked
  wire lk2 = lock_i[2];
  wire lk3 = lock_i[3];
  wire c0 = o01 & (o02 | lk2) & (o03 | lk3);
  wire c1 = ~o01 & (o12 | lk2) & (o13 | lk3);
  wire c2 = ~lk2 & ~o02 & ~o12 & (o23 | lk3);
  wire c3 = ~lk3 & ~o03 & ~o13 & ~o23;

  // Oldest unlocked way; a pattern that matches no way falls back to way 0
  always @* begin
    if (c3) begin
      victim_o = 2'h3;
    end else if (c2) begin
      victim_o = 2'h2;
    end else if (c1) begin
      victim_o = 2'h1;
    end else begin
      victim_o = 2'h0;
    end
  end

  // Accessed way becomes newest against all three others
  always @* begin
    touched_o = lru_i;
    case (touch_way_i)
      2'h0: begin
        touched_o[5] = 1'b0;
        touched_o[4] = 1'b0;
        touched_o[3] = 1'b0;
      end
      2'h1: begin
        touched_o[5] = 1'b1;
        touched_o[2] = 1'b0;
        touched_o[1] = 1'b0;
      end
      2'h2: begin
        touched_o[4] = 1'b1;
        touched_o[2] = 1'b1;
        touched_o[0] = 1'b0;
      end
      default: begin
        touched_o[3] = 1'b1;
        touched_o[1] = 1'b1;
        touched_o[0] = 1'b1;
      end
    endcase
  end
endmodule // ufc_lru_pick

// ### tb/ufc_cache_properties.sv
// Port-level checks for the unified four-way cache
`timescale 1ns/100ps
module ufc_cache_properties (
  // Clock and reset
  input wire CLOCK_I,
  input wire RST_I,
  // Register bus
  input wire HSEL_I,
  input wire [31:0] HADDR_I,
  input wire [1:0] HTRANS_I,
  input wire HWRITE_I,
  input wire HREADY_I,
  input wire HREADYOUT_O,
  input wire HRESP_O,
  input wire [31:0] HRDATA_O,
  // CPU and memory ports
  input wire CPU_REQ_I,
  input wire CPU_ACK_O,
  input wire MEM_REQ_O,
  input wire MEM_WE_O,
  input wire [31:0] MEM_ADDR_O,
  input wire [31:0] MEM_WDATA_O,
  input wire MEM_ACK_I
);
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (RST_I);
  wire rd_take = HSEL_I & HREADY_I & HTRANS_I[1] & ~HWRITE_I;
  wire ctl_take = rd_take & (HADDR_I[7:0] == 8'h00);
  // Bypass words open their request run; later line words never do
  reg run_on;
  always @(posedge CLOCK_I) begin
    if (RST_I || !MEM_REQ_O) begin
      run_on <= 1'b0;
    end else if (MEM_ACK_I) begin
      run_on <= 1'b1;
    end
  end
  // Cached traffic carries a masked address; bypass may not
  wire cached = MEM_REQ_O & MEM_ACK_I & run_on &
    (MEM_ADDR_O[31:29] == 3'h0);
  wire mid_word = MEM_ADDR_O[3:2] == 2'h1 || MEM_ADDR_O[3:2] == 2'h2;
  property p_ready;
    HREADYOUT_O && !HRESP_O;
  endproperty
  a_ready: assert property (p_ready) else $error("bus stalled or error");
  property p_rdata_idle;
    !$past(rd_take) |-> HRDATA_O == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("stray rdata");
  property p_ctl_read;
    $past(ctl_take) |-> HRDATA_O[31:3] == 29'h0000_0000;
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("ctrl bits");
  property p_ack_pulse;
    CPU_ACK_O |=> !CPU_ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_req;
    CPU_ACK_O |-> $past(CPU_REQ_I);
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack without req");
  property p_cpu_answer;
    $rose(CPU_REQ_I) |-> ##[1:200] CPU_ACK_O;
  endproperty
  a_cpu_answer: assert property (p_cpu_answer) else $error("no cpu ack");
  property p_mem_hold;
    MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O && $stable(MEM_ADDR_O)
      && $stable(MEM_WE_O) && $stable(MEM_WDATA_O);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("mem req moved");
  property p_burst_step;
    cached && mid_word |=> MEM_REQ_O && $stable(MEM_WE_O)
      && MEM_ADDR_O == $past(MEM_ADDR_O) + 32'h0000_0004;
  endproperty
  a_burst_step: assert property (p_burst_step) else $error("line step");
  property p_wb_fill;
    cached && MEM_WE_O && MEM_ADDR_O[3:2] == 2'h3 |=> MEM_REQ_O
      && !MEM_WE_O && MEM_ADDR_O[3:0] == 4'h0
      && ((MEM_ADDR_O ^ $past(MEM_ADDR_O)) & 32'h0000_0FF0) == 0;
  endproperty
  a_wb_fill: assert property (p_wb_fill) else $error("no refill");
  c_wb: cover property (cached && MEM_WE_O && MEM_ADDR_O[3:2] == 2'h3);
  c_fill: cover property (cached && !MEM_WE_O && MEM_ADDR_O[3:2] == 2'h3);
  c_ctl: cover property (ctl_take);
endmodule // ufc_cache_properties
bind ufc_cache ufc_cache_properties u_ufc_cache_properties (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
  .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I),
  .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .HRDATA_O(HRDATA_O),
  .CPU_REQ_I(CPU_REQ_I), .CPU_ACK_O(CPU_ACK_O), .MEM_REQ_O(MEM_REQ_O),
  .MEM_WE_O(MEM_WE_O), .MEM_ADDR_O(MEM_ADDR_O), .MEM_WDATA_O(MEM_WDATA_O),
  .MEM_ACK_I(MEM_ACK_I));

// ### tb/ufc_mem_model.sv
// Memory partner: acks each word after one or three cycles, counts traffic
`timescale 1ns/100ps
module ufc_mem_model (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Word request
  input wire req_i,
  input wire we_i,
  input wire [31:0] addr_i,
  input wire [31:0] wdata_i,
  // Answer and counts
  output reg ack_o,
  output wire [31:0] rdata_o,
  output reg [31:0] rd_cnt_o,
  output reg [31:0] wr_cnt_o,
  output reg [31:0] last_wr_o,
  output reg [31:0] last_wd_o
);
  reg [31:0] data_reg;
  reg [1:0] wait_reg;
  reg slow_reg;
  // Data lines show the inverse outside the ack cycle, never stale data
  assign rdata_o = ack_o ? data_reg : ~data_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      wait_reg <= 2'h0;
      slow_reg <= 1'b0;
      data_reg <= 32'h0000_0000;
      rd_cnt_o <= 32'h0000_0000;
      wr_cnt_o <= 32'h0000_0000;
      last_wr_o <= 32'h0000_0000;
      last_wd_o <= 32'h0000_0000;
    end else begin
      ack_o <= 1'b0;
      if (req_i && !ack_o && wait_reg != 2'h0) begin
        wait_reg <= wait_reg - 2'h1;
      end else if (req_i && !ack_o) begin
        ack_o <= 1'b1;
        wait_reg <= slow_reg ? 2'h2 : 2'h0;
        slow_reg <= ~slow_reg;
        data_reg <= addr_i ^ 32'h5A5A_0000;
        if (we_i) begin
          wr_cnt_o <= wr_cnt_o + 32'h0000_0001;
          last_wr_o <= addr_i;
          last_wd_o <= wdata_i;
        end else begin
          rd_cnt_o <= rd_cnt_o + 32'h0000_0001;
        end
      end
    end
  end
endmodule // ufc_mem_model

// ### tb/ufc_cache_test.sv
// Self-checking bench for the unified four-way cache
`timescale 1ns/100ps
`include "ufc_cache_regs.vh"
module ufc_cache_test;
  reg clk, rst, mrst, hsel, hwrite, creq, cwe;
  reg [1:0] htrans;
  reg [31:0] haddr, hwdata, caddr, cwdata, q, rd_snap, wr_snap;
  wire hrdyo, hresp, cack, mack;
  wire mreq, mwe;
  wire [31:0] hrdata, crdata, maddr, mwdata, mrdata, rd_cnt, wr_cnt, last_wr;
  wire [31:0] last_wd;
  integer num_errors, total_checks, i;
  localparam [31:0] MIX = 32'h5A5A_0000;
  ufc_cache u_ufc_cache (
    .CLOCK_I(clk), .RST_I(rst), .MRST_I(mrst), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
    .HWDATA_I(hwdata), .HREADY_I(hrdyo), .HREADYOUT_O(hrdyo),
    .HRESP_O(hresp), .HRDATA_O(hrdata), .CPU_REQ_I(creq), .CPU_WE_I(cwe),
    .CPU_ADDR_I(caddr), .CPU_WDATA_I(cwdata), .CPU_ACK_O(cack),
    .CPU_RDATA_O(crdata), .MEM_REQ_O(mreq), .MEM_WE_O(mwe),
    .MEM_ADDR_O(maddr), .MEM_WDATA_O(mwdata), .MEM_ACK_I(mack),
    .MEM_RDATA_I(mrdata));
  ufc_mem_model u_ufc_mem_model (
    .clk_i(clk), .rst_i(rst), .req_i(mreq), .we_i(mwe), .addr_i(maddr),
    .ack_o(mack), .rdata_o(mrdata), .rd_cnt_o(rd_cnt), .wr_cnt_o(wr_cnt),
    .last_wr_o(last_wr), .wdata_i(mwdata), .last_wd_o(last_wd));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // Waits on hready (sel 0) or cpu ack (sel 1), sampled at the edge
  task wait_for(input sel);
    integer n;
    begin
      n = 0;
      @(posedge clk);
      while ((sel ? cack : hrdyo) !== 1'b1) begin
        n = n + 1;
        if (n > 300) begin
          chk(32'h0000_0000, 32'h0000_0001);
          stop_test;
        end
        @(posedge clk);
      end
    end
  endtask
  task ahb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      wait_for(1'b0);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_for(1'b0);
      q = hrdata;
    end
  endtask
  task reg_chk(input [7:0] a, input [31:0] exp);
    begin
      ahb(1'b0, a, 32'h0000_0000);
      chk(q, exp);
    end
  endtask
  task cpu(input w, input [31:0] a, input [31:0] d);
    begin
      @(posedge clk);
      creq <= 1'b1;
      cwe <= w;
      caddr <= a;
      cwdata <= d;
      wait_for(1'b1);
      q = crdata;
      creq <= 1'b0;
    end
  endtask
  task mem_delta(input [2:0] dr, input [2:0] dw);
    begin
      chk(rd_cnt - rd_snap, {29'h0000_0000, dr});
      chk(wr_cnt - wr_snap, {29'h0000_0000, dw});
      rd_snap = rd_cnt;
      wr_snap = wr_cnt;
    end
  endtask
  task por;
    begin
      @(posedge clk);
      rst <= 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd_snap = 32'h0000_0000;
      wr_snap = 32'h0000_0000;
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {mrst, hsel, hwrite, creq, cwe, htrans} = 7'h00;
    {haddr, hwdata, caddr, cwdata, q} = 160'h0;
    num_errors = 0;
    total_checks = 0;
    por;
    reg_chk(`UFC_CTRL_OFS, 32'h0000_0000);
    reg_chk(`UFC_LOCK_OFS, 32'h0000_0000);
    ahb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    reg_chk(8'h0C, 32'h0000_0000);
    $display("test registers done");
    cpu(1'b0, 32'h0000_1000, 32'h0000_0000);
    chk(q, 32'h0000_1000 ^ MIX);
    mem_delta(3'h1, 3'h0);
    ahb(1'b1, `UFC_CTRL_OFS, 32'h0000_0001);
    cpu(1'b0, 32'h0000_1230, 32'h0000_0000);
    chk(q, 32'h0000_1230 ^ MIX);
    mem_delta(3'h4, 3'h0);
    cpu(1'b0, 32'h0000_1238, 32'h0000_0000);
    chk(q, 32'h0000_1238 ^ MIX);
    mem_delta(3'h0, 3'h0);
    cpu(1'b0, 32'h8000_1238, 32'h0000_0000);
    chk(q, 32'h0000_1238 ^ MIX);
    mem_delta(3'h0, 3'h0);
    for (i = 5; i < 8; i = i + 2) begin
      cpu(1'b0, {i[2:0], 29'h0000_1230}, 32'h0000_0000);
      chk(q, {i[2:0], 29'h0000_1230} ^ MIX);
      mem_delta(3'h1, 3'h0);
    end
    $display("test areas done");
    for (i = 2; i < 5; i = i + 1) begin
      cpu(1'b1, i * 32'h0000_1000 + 32'h0000_0230, 32'hCAFE_0000);
      mem_delta(3'h4, 3'h0);
    end
    cpu(1'b1, 32'h0000_1230, 32'h1234_5678);
    mem_delta(3'h0, 3'h0);
    cpu(1'b0, 32'h0000_1230, 32'h0000_0000);
    chk(q, 32'h1234_5678);
    for (i = 2; i < 4; i = i + 1) begin
      cpu(1'b0, (i + 3) * 32'h0000_1000 + 32'h0000_0230, 32'h0000_0000);
      mem_delta(3'h4, 3'h4);
      chk(last_wr, i * 32'h0000_1000 + 32'h0000_023C);
      chk(last_wd, (i * 32'h0000_1000 + 32'h0000_023C) ^ MIX);
    end
    $display("test replacement done");
    ahb(1'b1, `UFC_CTRL_OFS, 32'h0000_0009);
    reg_chk(`UFC_CTRL_OFS, 32'h0000_0001);
    cpu(1'b0, 32'h0000_4230, 32'h0000_0000);
    chk(q, 32'h0000_4230 ^ MIX);
    mem_delta(3'h4, 3'h0);
    ahb(1'b1, `UFC_CTRL_OFS, 32'h0000_0003);
    cpu(1'b1, 32'hC000_7230, 32'h0BAD_0000);
    mem_delta(3'h0, 3'h1);
    chk(last_wr, 32'h0000_7230);
    chk(last_wd, 32'h0BAD_0000);
    ahb(1'b1, `UFC_CTRL_OFS, 32'h0000_0005);
    cpu(1'b1, 32'h8000_8230, 32'h0BAD_0001);
    mem_delta(3'h4, 3'h0);
    $display("test flush and policy done");
    @(posedge clk);
    mrst <= 1'b1;
    repeat (2) @(posedge clk);
    mrst <= 1'b0;
    reg_chk(`UFC_CTRL_OFS, 32'h0000_0000);
    ahb(1'b1, `UFC_CTRL_OFS, 32'h0000_0001);
    cpu(1'b0, 32'h0000_4230, 32'h0000_0000);
    chk(q, 32'h0000_4230 ^ MIX);
    mem_delta(3'h0, 3'h0);
    por;
    ahb(1'b1, `UFC_CTRL_OFS, 32'h0000_0001);
    cpu(1'b0, 32'h0000_8230, 32'h0000_0000);
    mem_delta(3'h4, 3'h0);
    $display("test resets done");
    ahb(1'b1, `UFC_LOCK_OFS, 32'h0001_0101);
    reg_chk(`UFC_LOCK_OFS, 32'h0001_0101);
    for (i = 9; i < 13; i = i + 1) begin
      cpu(1'b0, i * 32'h0000_1000 + 32'h0000_0230, 32'h0000_0000);
      mem_delta(3'h4, 3'h0);
    end
    cpu(1'b0, 32'h0000_8230, 32'h0000_0000);
    chk(q, 32'h0000_8230 ^ MIX);
    mem_delta(3'h0, 3'h0);
    reg_chk(`UFC_STAT_OFS, 32'h0000_0002);
    $display("test locking done");
    stop_test;
  end
endmodule // ufc_cache_test
